/* File: hdl/card_common_memory_port.sv */
/*
 * Host controller for a removable storage card in common memory mode.
 * Assumes the user side holds a request until accepted, and that the card
 * drives data only while the read strobe is low.
 */
`timescale 1ns/1ns
module card_common_memory_port
(
   input  wire logic                                clk,
   input  wire logic                                srst,
   input  wire logic                                reqValid,
   output logic                                     reqReady,
   input  wire logic                                reqWrite,
   input  wire logic                                reqAttribute,
   input  wire logic [card_port_pkg::ADDR_W-1:1]   reqAddr,
   input  wire logic [card_port_pkg::DATA_W-1:0]   reqData,
   output logic                                     rspValid,
   output logic [card_port_pkg::DATA_W-1:0]         rspData,
   output logic                                     cardSeated,
   input  wire logic                                cardPresentPin_n,
   output logic [card_port_pkg::ADDR_W-1:0]         cardAddr,
   input  wire logic [card_port_pkg::DATA_W-1:0]    cardDataIn,
   output logic [card_port_pkg::DATA_W-1:0]         cardDataOut,
   output logic                                     cardDataOe,
   output logic                                     cardRead_n,
   output logic                                     cardWrite_n,
   output logic                                     cardSpaceSel,
   output logic                                     card_enable_low_n,
   output logic                                     card_enable_high_n
);

   // ****************************************************************
   // Card detect
   // ****************************************************************
   card_sync_if detect ();

   card_detect_sync u_card_detect_sync
   (
      .clk              (clk),
      .srst             (srst),
      .cardPresentPin_n (cardPresentPin_n),
      .syncOut          (detect.source)
   );

   // ****************************************************************
   // Data capture
   // ****************************************************************
   logic [card_port_pkg::DATA_W-1:0]      dataStage1_reg, dataStage1_next;
   logic [card_port_pkg::DATA_W-1:0]      dataStage2_reg, dataStage2_next;

   // The card drives its data lines with no relation to clk, so they pass two
   // flops before the capture mux; the long strobe hides the two-cycle lag.
   always_comb
   begin
      dataStage1_next = cardDataIn;
      dataStage2_next = dataStage1_reg;
   end

   // Registers only.
   always_ff @(posedge clk)
   begin
      dataStage1_reg <= dataStage1_next;
      dataStage2_reg <= dataStage2_next;
   end

   // ****************************************************************
   // Access sequencer
   // ****************************************************************
   card_port_pkg::phase_e                 phase_reg, phase_next;
   logic [card_port_pkg::CNT_W-1:0]       cnt_reg, cnt_next;
   logic                                  write_reg, write_next;
   logic                                  space_reg, space_next;
   logic [card_port_pkg::ADDR_W-1:1]      addr_reg, addr_next;
   logic [card_port_pkg::DATA_W-1:0]      wdata_reg, wdata_next;
   logic [card_port_pkg::DATA_W-1:0]      rdata_reg, rdata_next;
   logic                                  rsp_reg, rsp_next;
   logic                                  bank_reg, bank_next;
   logic                                  rd_reg, rd_next;
   logic                                  wr_reg, wr_next;

   // Accept only when idle and the card is seated.
   assign reqReady = (phase_reg == card_port_pkg::IDLE) && detect.present;

   // Next-state logic: setup, stretched strobe, hold, with request fields frozen.
   always_comb
   begin
      phase_next = phase_reg;
      cnt_next   = cnt_reg;
      write_next = write_reg;
      space_next = space_reg;
      addr_next  = addr_reg;
      wdata_next = wdata_reg;
      rdata_next = rdata_reg;
      rsp_next   = 1'b0;
      bank_next  = bank_reg;
      rd_next    = 1'b1;
      wr_next    = 1'b1;
      unique case (phase_reg)
         card_port_pkg::IDLE:
         begin
            bank_next = 1'b1;
            if (reqValid && reqReady)
            begin
               write_next = reqWrite;
               // High selects common memory, low attribute memory.
               space_next = reqAttribute ? card_port_pkg::SPACE_ATTRIBUTE
                                         : card_port_pkg::SPACE_COMMON;
               addr_next  = reqAddr;
               wdata_next = reqData;
               bank_next  = 1'b0;
               cnt_next   = card_port_pkg::CNT_ZERO;
               phase_next = card_port_pkg::SETUP;
            end
         end
         card_port_pkg::SETUP:
         begin
            if (cnt_reg == card_port_pkg::SETUP_LAST)
            begin
               cnt_next   = card_port_pkg::CNT_ZERO;
               phase_next = card_port_pkg::STROBE;
               rd_next    = write_reg;
               wr_next    = ~write_reg;
            end
            else
            begin
               cnt_next = cnt_reg + 6'h01;
            end
         end
         card_port_pkg::STROBE:
         begin
            if (cnt_reg == card_port_pkg::STROBE_LAST)
            begin
               // Sample at the end of the stretched strobe, data is settled.
               if (!write_reg)
               begin
                  rdata_next = dataStage2_reg;
               end
               cnt_next   = card_port_pkg::CNT_ZERO;
               phase_next = card_port_pkg::HOLD;
            end
            else
            begin
               cnt_next = cnt_reg + 6'h01;
               rd_next  = rd_reg;
               wr_next  = wr_reg;
            end
         end
         card_port_pkg::HOLD:
         begin
            // Enables and address outlive the strobe by the hold time.
            if (cnt_reg == card_port_pkg::HOLD_LAST)
            begin
               bank_next  = 1'b1;
               rsp_next   = 1'b1;
               phase_next = card_port_pkg::IDLE;
            end
            else
            begin
               cnt_next = cnt_reg + 6'h01;
            end
         end
         default:
         begin
            phase_next = card_port_pkg::IDLE;
         end
      endcase
      if (srst)
      begin
         phase_next = card_port_pkg::IDLE;
         cnt_next   = card_port_pkg::CNT_ZERO;
         write_next = 1'b0;
         space_next = card_port_pkg::SPACE_COMMON;
         addr_next  = '0;
         wdata_next = '0;
         rdata_next = '0;
         rsp_next   = 1'b0;
         bank_next  = 1'b1;
         rd_next    = 1'b1;
         wr_next    = 1'b1;
      end
   end

   // Registers only.
   always_ff @(posedge clk)
   begin
      phase_reg <= phase_next;
      cnt_reg   <= cnt_next;
      write_reg <= write_next;
      space_reg <= space_next;
      addr_reg  <= addr_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      rsp_reg   <= rsp_next;
      bank_reg  <= bank_next;
      rd_reg    <= rd_next;
      wr_reg    <= wr_next;
   end

   // ****************************************************************
   // Pin drive
   // ****************************************************************
   // Both enables share one bank select, so the card always sees words.
   assign card_enable_low_n  = bank_reg;
   assign card_enable_high_n = bank_reg;
   assign cardAddr           = {addr_reg, card_port_pkg::ADDR0_LEVEL};
   assign cardSpaceSel       = space_reg;
   assign cardRead_n         = rd_reg;
   assign cardWrite_n        = wr_reg;
   // Drive the bus for the whole write access so data surrounds the strobe.
   assign cardDataOe         = write_reg && (phase_reg != card_port_pkg::IDLE);
   assign cardDataOut        = wdata_reg;
   assign rspValid           = rsp_reg;
   assign rspData            = rdata_reg;
   assign cardSeated         = detect.present;

endmodule // card_common_memory_port

/* File: hdl/card_detect_sync.sv */
/*
 * Two-flop synchroniser for the card-detect pin.
 * Assumes the pin is asynchronous to clk.
 */
`timescale 1ns/1ns
module card_detect_sync
(
   input  wire logic     clk,
   input  wire logic     srst,
   input  wire logic     cardPresentPin_n,
   card_sync_if.source   syncOut
);
   logic stage1_reg;
   logic stage2_reg;
   logic stage1_next;
   logic stage2_next;

   // Reset loads both stages with the absent level; a pin change reaches present two clocks later.
   always_comb
   begin
      stage1_next = cardPresentPin_n;
      stage2_next = stage1_reg;
      if (srst)
      begin
         stage1_next = 1'b1;
         stage2_next = 1'b1;
      end
   end

   // Registers only.
   always_ff @(posedge clk)
   begin
      stage1_reg <= stage1_next;
      stage2_reg <= stage2_next;
   end

   assign syncOut.present = ~stage2_reg;
endmodule // card_detect_sync

/* File: hdl/card_port_pkg.sv */
/*
 * Constants for the host-side card common memory port.
 * Assumes a 125 MHz system clock; the card itself has no clock.
 */
package card_port_pkg;

   // ****************************************************************
   // Widths
   // ****************************************************************
   localparam int DATA_W = 16;
   localparam int ADDR_W = 11;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_PERIOD_NS   = 8;
   localparam int ACCESS_TIME_NS  = 300;
   // Strobe width covers the slowest card access, rounded up.
   localparam int STROBE_CYCLES   = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETUP_CYCLES    = 1;
   localparam int HOLD_CYCLES     = 1;
   localparam int CNT_W           = 6;
   localparam logic [CNT_W-1:0] STROBE_LAST = CNT_W'(STROBE_CYCLES - 1);
   localparam logic [CNT_W-1:0] SETUP_LAST  = CNT_W'(SETUP_CYCLES - 1);
   localparam logic [CNT_W-1:0] HOLD_LAST   = CNT_W'(HOLD_CYCLES - 1);
   localparam logic [CNT_W-1:0] CNT_ZERO    = 6'h00;

   // ****************************************************************
   // Pin levels
   // ****************************************************************
   localparam logic SPACE_COMMON    = 1'b1;
   localparam logic SPACE_ATTRIBUTE = 1'b0;
   localparam logic ADDR0_LEVEL     = 1'b0;

   typedef enum logic [2:0] {IDLE, SETUP, STROBE, HOLD} phase_e;

endpackage

/* File: hdl/card_sync_if.sv */
/*
 * Interface carrying the synchronised card-detect level to the main module.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ns
interface card_sync_if;
   logic present;
   modport source (output present);
   modport sink   (input  present);
endinterface // card_sync_if

/* File: verif/card_model.sv */
/* Behavioural card: one word register per address in each space.
   Assumes the host pins of card_common_memory_port. */
`timescale 1ns/1ns
module card_model
(
   input wire logic        clk,
   input wire logic        inserted,
   output logic            cardPresentPin_n,
   input wire logic [10:0] cardAddr,
   input wire logic [15:0] cardDataOut,
   output logic [15:0]     cardDataIn,
   input wire logic        cardRead_n,
   input wire logic        cardWrite_n,
   input wire logic        cardSpaceSel,
   input wire logic        card_enable_low_n,
   input wire logic        card_enable_high_n
);
   logic [15:0] mem [2048];
   logic [15:0] lastOut = 16'h0000;
   logic        wordSel;
   logic        driving;
   // Only both enables low select a word access.
   assign cardPresentPin_n = !inserted;
   assign wordSel = card_enable_low_n === 1'b0 && card_enable_high_n === 1'b0;
   assign driving = wordSel && cardRead_n === 1'b0;
   // A released bus shows the inverse word, so a late sample cannot match by luck.
   assign cardDataIn = driving ? mem[{cardSpaceSel, cardAddr[10:1]}] : ~lastOut;
   always @(posedge clk) if (driving) lastOut <= cardDataIn;
   // Write data is latched as the write strobe rises.
   always @(posedge cardWrite_n) if (wordSel) mem[{cardSpaceSel, cardAddr[10:1]}] <= cardDataOut;
endmodule // card_model

/* File: verif/card_port_monitor.sv */
/* Checker on the card pins and request side of the port.
   Assumes it is bound into card_common_memory_port. */
`timescale 1ns/1ns
module card_port_monitor
(
   input wire logic        clk,
   input wire logic        srst,
   input wire logic        reqValid,
   input wire logic        reqReady,
   input wire logic        reqAttribute,
   input wire logic [10:1] reqAddr,
   input wire logic        rspValid,
   input wire logic        cardSeated,
   input wire logic [10:0] cardAddr,
   input wire logic        cardDataOe,
   input wire logic        cardRead_n,
   input wire logic        cardWrite_n,
   input wire logic        cardSpaceSel,
   input wire logic        card_enable_low_n,
   input wire logic        card_enable_high_n
);
   // ****************************************
   // Strobe width counter and properties
   // ****************************************
   logic       strobeLow;
   logic [7:0] lowCnt_reg;
   logic [7:0] lowCnt_next;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // Either strobe low means the card is being accessed.
   assign strobeLow = !cardRead_n || !cardWrite_n;
   // Counts sampled low cycles, so a short strobe shows at its rise.
   always_comb lowCnt_next = strobeLow ? lowCnt_reg + 8'h01 : 8'h00;
   always_ff @(posedge clk) lowCnt_reg <= srst ? 8'h00 : lowCnt_next;
   sequence s_taken;
      reqValid && reqReady;
   endsequence
   sequence s_open;
      $fell(card_enable_low_n);
   endsequence
   a_answer_time: assert property (s_taken |-> ##41 rspValid)
      else $error("response not 41 cycles after request");
   a_space_addr: assert property (s_open |-> cardSpaceSel == !$past(reqAttribute)
      && cardAddr[10:1] == $past(reqAddr))
      else $error("space or address differs from request");
   a_seated_first: assert property (s_open |-> $past(cardSeated))
      else $error("access opened without a seated card");
   a_strobe_width: assert property ($rose(cardRead_n && cardWrite_n)
      |-> lowCnt_reg == 8'(card_port_pkg::STROBE_CYCLES))
      else $error("strobe width wrong");
   a_pins_stable: assert property (strobeLow
      |-> $stable(cardAddr) && $stable(cardSpaceSel) ##1 $stable(cardAddr))
      else $error("address moved around strobe");
   a_strobes_apart: assert property (cardRead_n || cardWrite_n)
      else $error("both strobes low");
   a_enables_cover: assert property (strobeLow |-> !card_enable_low_n)
      else $error("enable high during strobe");
   a_enables_pair: assert property (card_enable_low_n == card_enable_high_n)
      else $error("enables differ");
   a_addr_even: assert property (cardAddr[0] == 1'b0)
      else $error("address bit zero high");
   a_drive_dir: assert property (strobeLow |-> cardDataOe == !cardWrite_n)
      else $error("data direction wrong");
endmodule // card_port_monitor
bind card_common_memory_port card_port_monitor u_card_port_monitor
   (.clk(clk), .srst(srst), .reqValid(reqValid), .reqReady(reqReady),
    .reqAttribute(reqAttribute), .reqAddr(reqAddr), .rspValid(rspValid),
    .cardSeated(cardSeated), .cardAddr(cardAddr), .cardDataOe(cardDataOe),
    .cardRead_n(cardRead_n), .cardWrite_n(cardWrite_n), .cardSpaceSel(cardSpaceSel),
    .card_enable_low_n(card_enable_low_n), .card_enable_high_n(card_enable_high_n));

/* File: verif/test_card_common_memory_port.sv */
/* Self-checking bench for card_common_memory_port with a card model.
   Assumes a 125 MHz clock and a fixed access length. */
`timescale 1ns/1ns
module test_card_common_memory_port;
   logic clk = 1'b0, srst = 1'b1, reqValid = 1'b0, reqWrite = 1'b0, reqAttribute = 1'b0;
   logic inserted = 1'b0, reqReady, rspValid, cardSeated, cardPresentPin_n, cardDataOe;
   logic cardRead_n, cardWrite_n, cardSpaceSel, ceLow_n, ceHigh_n;
   logic [10:1] reqAddr = 10'h000, ad;
   logic [15:0] reqData = 16'h0000, rspData, cardDataIn, cardDataOut, refMem [2048];
   logic [10:0] cardAddr;
   logic [16:0] expQ [$], e;
   int nErrors = 0, checkCount = 0, cycles = 0;
   card_common_memory_port u_card_common_memory_port (.clk(clk), .srst(srst),
      .reqValid(reqValid), .reqReady(reqReady), .reqWrite(reqWrite),
      .reqAttribute(reqAttribute), .reqAddr(reqAddr), .reqData(reqData),
      .rspValid(rspValid), .rspData(rspData), .cardSeated(cardSeated),
      .cardPresentPin_n(cardPresentPin_n), .cardAddr(cardAddr), .cardDataIn(cardDataIn),
      .cardDataOut(cardDataOut), .cardDataOe(cardDataOe), .cardRead_n(cardRead_n),
      .cardWrite_n(cardWrite_n), .cardSpaceSel(cardSpaceSel),
      .card_enable_low_n(ceLow_n), .card_enable_high_n(ceHigh_n));
   card_model u_card_model (.clk(clk), .inserted(inserted), .cardPresentPin_n(cardPresentPin_n),
      .cardAddr(cardAddr), .cardDataOut(cardDataOut), .cardDataIn(cardDataIn),
      .cardRead_n(cardRead_n), .cardWrite_n(cardWrite_n), .cardSpaceSel(cardSpaceSel),
      .card_enable_low_n(ceLow_n), .card_enable_high_n(ceHigh_n));
   // ****************************************
   // Tasks, clock and checks
   // ****************************************
   task automatic stop_test();
      if (nErrors == 0 && checkCount > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Holds the request until taken, then notes what the answer must carry.
   task automatic access(input logic w, input logic a, input logic [10:1] d_ad);
      @(negedge clk);
      reqValid = 1'b1;
      reqWrite = w;
      reqAttribute = a;
      reqAddr = d_ad;
      reqData = 16'($urandom);
      forever
      begin
         @(posedge clk);
         if (reqReady === 1'b1) break;
      end
      if (w) refMem[{a, d_ad}] = reqData;
      expQ.push_back(w ? 17'h00000 : {1'b1, refMem[{a, d_ad}]});
      @(negedge clk);
      reqValid = 1'b0;
   endtask
   initial forever #4 clk = ~clk;
   // Each answer takes the oldest note; an answer with no note is a mismatch.
   always @(posedge clk)
   begin
      cycles++;
      if (rspValid === 1'b1)
      begin
         e = (expQ.size() != 0) ? expQ.pop_front() : 17'h1XXXX;
         checkCount++;
         if (e[16] !== 1'b0 && rspData !== e[15:0])
         begin
            nErrors++;
            $display("wrong value rspData expected %h seen %h", e[15:0], rspData);
         end
      end
      if (cycles == 6000)
      begin
         nErrors++;
         stop_test();
      end
   end
   // Refused while no card, then both spaces written and read back.
   initial
   begin
      void'($urandom(32'hCCB7));
      repeat (12) @(negedge clk);
      srst = 1'b0;
      reqValid = 1'b1;
      repeat (20)
      begin
         @(posedge clk);
         checkCount++;
         if (reqReady !== 1'b0 || cardSeated !== 1'b0 || ceLow_n !== 1'b1)
         begin
            nErrors++;
            $display("wrong value reqReady expected 0 seen %b", reqReady);
         end
      end
      @(negedge clk);
      inserted = 1'b1;
      for (int i = 0; i < 12; i++)
      begin
         ad = (i < 2) ? {10{i[0]}} : 10'($urandom);
         access(1'b1, 1'b0, ad);
         access(1'b1, 1'b1, ad);
         access(1'b0, 1'b0, ad);
         access(1'b0, 1'b1, ad);
      end
      repeat (60) @(posedge clk);
      checkCount++;
      if (expQ.size() != 0)
      begin
         nErrors++;
         $display("wrong value pending expected 0 seen %0d", expQ.size());
      end
      stop_test();
   end
endmodule // test_card_common_memory_port
